// ### hdl/wdog_config_guard.sv
// watchdog configuration guard: control register, safety levels, timed
// unlock window and the time-out counter that resets the chip
// assumes fuse levels are stable while rst_in is high and that the
// oscillator tick and kick inputs are synchronous one-cycle pulses
//
// Added by the designer: the strobed register port and the address map.

//////////////////////////////////////////////////////////////////////////
module wdog_config_guard #(
   parameter logic [21:0] BASE_TICKS = 22'h004000  // shortest period ticks
) (
   input  wire logic                           clock_in,   // 40 MHz clock
   input  wire logic                           rst_in,     // sync reset
   input  wire logic                           legacy_compat_fuse_in, // set
   input  wire logic                           wdog_always_on_fuse_in, // set
   input  wire logic [wdog_pkg::ADDR_W-1:0]    addr_in,    // reg address
   input  wire logic [wdog_pkg::DATA_W-1:0]    wr_data_in, // write data
   input  wire logic                           wr_en_in,   // write strobe
   input  wire logic                           rd_en_in,   // read strobe
   input  wire logic                           wdog_kick_in, // reset count
   input  wire logic                           osc_tick_in,  // osc tick
   output logic [wdog_pkg::DATA_W-1:0]         rd_data_out,  // read data
   output logic                                wdog_running_out, // active
   output logic                                chip_reset_out    // timeout
);
   import wdog_pkg::*;

   guard_state_s st_reg;
   guard_state_s st_next;
   ctrl_byte_s   wr;
   ctrl_byte_s   rd_view;
   logic [1:0]   level;
   logic         hit_wr;
   logic         hit_rd;
   logic         window_open;
   logic         unlock;
   logic         counter_clear;

   ////////////////////////////////////////////////////////////////////////
   // decode of the fuses held since reset into a safety level
   function automatic logic [1:0] level_of(input logic legacy,
                                           input logic always_on);
      logic [1:0] lv;
      lv = LEVEL1;
      if (always_on) begin
         lv = LEVEL2;
      end else if (legacy) begin
         lv = LEVEL0;
      end
      return lv;
   endfunction

   // the always-on fuse outranks the legacy fuse
   assign level = level_of(st_reg.fuse_legacy,
                           st_reg.fuse_always_on);

   // register port decode
   assign wr          = ctrl_byte_s'(wr_data_in);
   assign hit_wr      = wr_en_in && (addr_in == CTRL_ADDR);
   assign hit_rd      = rd_en_in && (addr_in == CTRL_ADDR);
   assign window_open = (st_reg.window != WINDOW_SHUT);
   assign unlock      = hit_wr && wr.change_en && wr.enable;

   // read view: reserved bits zero, enable forced at level two
   always_comb begin
      rd_view           = '0;
      rd_view.change_en = window_open;
      rd_view.enable    = st_reg.en || (level == LEVEL2);
      rd_view.prescale  = st_reg.prescale;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state; fuses are sampled only while reset is held, so a
   // fuse that moves later cannot loosen protection at run time
   always_comb begin
      st_next         = st_reg;
      st_next.rd_data = READ_IDLE;
      if (rst_in) begin
         st_next                = '0;
         st_next.prescale       = PRESCALE_RESET;
         st_next.fuse_legacy    = legacy_compat_fuse_in;
         st_next.fuse_always_on = wdog_always_on_fuse_in;
      end else begin
         // window ticks down every cycle and shuts by itself
         if (window_open) begin
            st_next.window = st_reg.window - 3'h1;
         end
         if (hit_wr) begin
            // a fresh unlock re-arms the full window
            if (unlock) begin
               st_next.window = UNLOCK_CYCLES;
            end
            // enabling is never restricted
            if (wr.enable) begin
               st_next.en = 1'b1;
            end else if (window_open && (level != LEVEL2)) begin
               st_next.en = 1'b0;
            end
            // else the disable is dropped silently
            // written enable is irrelevant at level two
            if (level == LEVEL0) begin
               st_next.prescale = wr.prescale;
            end else if (window_open && !wr.change_en) begin
               st_next.prescale = wr.prescale;
            end
            // above level zero, outside the window prescale is kept
         end
         if (hit_rd) begin
            st_next.rd_data = DATA_W'(rd_view);
         end
      end
      // level of the fuses just latched, read back inside this process so
      // no separate net loops from st_next into itself
      st_next.running = st_next.en ||
                        (level_of(st_next.fuse_legacy,
                                  st_next.fuse_always_on) == LEVEL2);
   end

   always_ff @(posedge clock_in) begin
      st_reg <= st_next;
   end

   assign rd_data_out      = st_reg.rd_data;
   assign wdog_running_out = st_reg.running;

   ////////////////////////////////////////////////////////////////////////
   // counter restarts on a kick and whenever the watchdog is off
   assign counter_clear = wdog_kick_in || !st_reg.running;

   wdog_counter #(
      .BASE        (BASE_TICKS)
   ) u_counter (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .clear_in    (counter_clear),
      .tick_in     (osc_tick_in),
      .prescale_in (st_reg.prescale),
      .expire_out  (chip_reset_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks on the protection logic
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   property p_window_holds;
      unlock |=> window_open [*4];
   endproperty
   a_window_holds: assert property (p_window_holds)
      else $error("unlock window shorter than four cycles");

   property p_window_shuts;
      unlock ##1 (!unlock) [*4] |=> !window_open;
   endproperty
   a_window_shuts: assert property (p_window_shuts)
      else $error("unlock window did not close");

   property p_enable_free;
      hit_wr && wr.enable |=> st_reg.en && wdog_running_out;
   endproperty
   a_enable_free: assert property (p_enable_free)
      else $error("enable write not taken");

   property p_level0_prescale;
      hit_wr && (level == LEVEL0) |=>
         st_reg.prescale == $past(wr.prescale);
   endproperty
   a_level0_prescale: assert property (p_level0_prescale)
      else $error("level zero prescale write lost");

   property p_no_disable_shut;
      hit_wr && !wr.enable && !window_open && st_reg.en |=> st_reg.en;
   endproperty
   a_no_disable_shut: assert property (p_no_disable_shut)
      else $error("disabled without unlock");

   property p_prescale_locked;
      hit_wr && (level != LEVEL0) && !window_open |=>
         $stable(st_reg.prescale);
   endproperty
   a_prescale_locked: assert property (p_prescale_locked)
      else $error("prescale changed outside window");

   property p_level1_apply;
      hit_wr && window_open && !wr.change_en && (level == LEVEL1) |=>
         (st_reg.prescale == $past(wr.prescale)) &&
         (st_reg.en == $past(wr.enable));
   endproperty
   a_level1_apply: assert property (p_level1_apply)
      else $error("level one unlocked write not applied");

   property p_level2_apply;
      hit_wr && window_open && !wr.change_en && (level == LEVEL2) |=>
         (st_reg.prescale == $past(wr.prescale)) && wdog_running_out;
   endproperty
   a_level2_apply: assert property (p_level2_apply)
      else $error("level two unlocked write mishandled");

   property p_level2_reads_one;
      hit_rd && (level == LEVEL2) |=> rd_data_out[3] && wdog_running_out;
   endproperty
   a_level2_reads_one: assert property (p_level2_reads_one)
      else $error("level two enable not reading one");

   property p_idle_read_zero;
      !hit_rd |=> rd_data_out == READ_IDLE;
   endproperty
   a_idle_read_zero: assert property (p_idle_read_zero)
      else $error("read data outside read slot");

   c_level1_change: cover property (
      unlock && (level == LEVEL1) ##2 hit_wr && !wr.change_en);
   c_level0_disable: cover property (
      (level == LEVEL0) && unlock ##1 hit_wr && !wr.enable);
   c_level2_unlock: cover property ((level == LEVEL2) && unlock);
   c_chip_reset: cover property (chip_reset_out);
endmodule

// ### hdl/wdog_counter.sv
// time-out counter: counts watchdog oscillator ticks up to the selected
// period and pulses expire; assumes ticks are synchronous one-cycle pulses
module wdog_counter #(
   parameter logic [21:0] BASE = 22'h004000    // ticks for the shortest period
) (
   input  wire logic                  clock_in,     // system clock
   input  wire logic                  rst_in,       // sync reset, high
   input  wire logic                  clear_in,     // restart the count
   input  wire logic                  tick_in,      // oscillator tick pulse
   input  wire logic [2:0]            prescale_in,  // period select
   output logic                       expire_out    // one-cycle time-out
);
   import wdog_pkg::*;

   counter_state_s   st_reg;
   counter_state_s   st_next;
   logic [CNT_W-1:0] last_tick;

   // period doubles with each prescale step
   assign last_tick = (BASE << prescale_in) - 22'h000001;

   ////////////////////////////////////////////////////////////////////////
   // next state: clear wins over counting so a kick never loses a race
   always_comb begin
      st_next        = st_reg;
      st_next.expire = 1'b0;
      if (rst_in) begin
         st_next = '0;
      end else if (clear_in) begin
         st_next.count = '0;
      end else if (tick_in) begin
         if (st_reg.count >= last_tick) begin
            st_next.count  = '0;
            st_next.expire = 1'b1;
         end else begin
            st_next.count = st_reg.count + 22'h000001;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      st_reg <= st_next;
   end

   assign expire_out = st_reg.expire;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   property p_clear_restarts;
      clear_in |=> (st_reg.count == '0) && !expire_out;
   endproperty
   a_clear_restarts: assert property (p_clear_restarts)
      else $error("count not restarted by clear");

   property p_period_end;
      tick_in && !clear_in && (st_reg.count == last_tick) |=>
         expire_out && (st_reg.count == '0);
   endproperty
   a_period_end: assert property (p_period_end)
      else $error("no expire at end of period");

   c_expire: cover property (expire_out);
endmodule

// ### include/wdog_pkg.sv
// constants, field layouts and state records for the watchdog config guard
// assumes one 40 MHz system clock and a synchronous active-high reset
package wdog_pkg;

   // register port widths and the single mapped address
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 8;
   localparam logic [7:0]  CTRL_ADDR    = 8'h00;
   localparam logic [7:0]  READ_IDLE    = 8'h00;

   // timed unlock window length in system clock cycles
   localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;
   localparam logic [2:0]  WINDOW_SHUT   = 3'h0;

   // watchdog counter sizing, in watchdog oscillator cycles
   localparam int          CNT_W        = 22;
   localparam int          PRESCALE_W   = 3;
   localparam int          BASE_TICKS   = 16384;
   localparam logic [2:0]  PRESCALE_RESET = 3'h0;

   // safety level codes
   localparam logic [1:0]  LEVEL0       = 2'h0;
   localparam logic [1:0]  LEVEL1       = 2'h1;
   localparam logic [1:0]  LEVEL2       = 2'h2;

   // control byte layout, msb first
   typedef struct packed {
      logic [2:0]            reserved;
      logic                  change_en;
      logic                  enable;
      logic [PRESCALE_W-1:0] prescale;
   } ctrl_byte_s;

   // state of the protection logic
   typedef struct packed {
      logic                  fuse_legacy;
      logic                  fuse_always_on;
      logic                  en;
      logic                  running;
      logic [PRESCALE_W-1:0] prescale;
      logic [2:0]            window;
      logic [DATA_W-1:0]     rd_data;
   } guard_state_s;

   // state of the time-out counter
   typedef struct packed {
      logic [CNT_W-1:0]      count;
      logic                  expire;
   } counter_state_s;

endpackage

// ### tb/watchdog_config_protect_tb.sv
// self-checking bench for the watchdog configuration guard
// assumes wdog_pkg is compiled first; a queue-free integer model runs beside
//////////////////////////////////////////////////////////////////////////
module watchdog_config_protect_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import wdog_pkg::*;

   localparam logic [21:0] BASE = 22'h000010;  // short period keeps run brief
   // directed ops: [9:8] 0 idle, 1 write, 2 read; [7:0] data
   localparam logic [9:0] SEQ [24] = '{10'h200, 10'h108, 10'h200, 10'h100,
      10'h200, 10'h105, 10'h200, 10'h118, 10'h200, 10'h103, 10'h200, 10'h11d,
      10'h000, 10'h000, 10'h000, 10'h000, 10'h102, 10'h200, 10'h118, 10'h200,
      10'h200, 10'h200, 10'h106, 10'h200};

   logic       clock_in, rst_in, legacy_compat_fuse_in, wdog_always_on_fuse_in;
   logic [7:0] addr_in, wr_data_in, rd_data_out, exp_rd;
   logic       wr_en_in, rd_en_in, wdog_kick_in, osc_tick_in;
   logic       wdog_running_out, chip_reset_out, exp_rst, exp_run;
   bit         checking, w, r, k, t;
   int         num_errors, tests_run, cycles, lvl, en, pre, win, cnt;

   wdog_config_guard #(.BASE_TICKS(BASE)) DUT (
      .clock_in               (clock_in),
      .rst_in                 (rst_in),
      .legacy_compat_fuse_in  (legacy_compat_fuse_in),
      .wdog_always_on_fuse_in (wdog_always_on_fuse_in),
      .addr_in                (addr_in),
      .wr_data_in             (wr_data_in),
      .wr_en_in               (wr_en_in),
      .rd_en_in               (rd_en_in),
      .wdog_kick_in           (wdog_kick_in),
      .osc_tick_in            (osc_tick_in),
      .rd_data_out            (rd_data_out),
      .wdog_running_out       (wdog_running_out),
      .chip_reset_out         (chip_reset_out)
   );

   // 40 MHz system clock
   always #12.5 clock_in = ~clock_in;

   //////////////////////////////////////////////////////////////////////////
   task automatic report(input string m);
      num_errors++;
      $display("unexpected %0t %s", $time, m);
   endtask

   task automatic tally_and_finish();
      if (num_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one bus cycle plus the model's view of the same edge
   task automatic step(input bit sw, sr, sk, st, input logic [7:0] a, d);
      bit in_win;
      wr_en_in     <= sw;
      rd_en_in     <= sr;
      wdog_kick_in <= sk;
      osc_tick_in  <= st;
      addr_in      <= a;
      wr_data_in   <= d;
      @(posedge clock_in);
      in_win = win > 0;
      // read data stand only in the cycle after a mapped read
      exp_rd = (sr && a == CTRL_ADDR) ?
               {3'h0, in_win, 1'(en != 0 || lvl == 2), 3'(pre)} : 8'h00;
      exp_rst = 1'b0;
      // the counter clears on a kick or while stopped; a kick beats a tick
      if (sk || !(en != 0 || lvl == 2))
         cnt = 0;
      else if (st) begin
         if (cnt == (int'(BASE) << pre) - 1) begin
            exp_rst = 1'b1;
            cnt = 0;
         end else
            cnt++;
      end
      win = in_win ? win - 1 : 0;
      if (sw && a == CTRL_ADDR) begin
         if (d[3])
            en = 1;
         else if (in_win && lvl != 2)
            en = 0;
         if (lvl == 0 || (in_win && !d[4]))
            pre = d[2:0];
         if (d[4] && d[3])
            win = int'(UNLOCK_CYCLES);
      end
      exp_run = en != 0 || lvl == 2;
   endtask

   task automatic do_reset(input bit legacy, ao);
      checking = 1'b0;
      legacy_compat_fuse_in  <= legacy;
      wdog_always_on_fuse_in <= ao;
      rst_in   <= 1'b1;
      wr_en_in <= 1'b0;
      rd_en_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      lvl = ao ? 2 : (legacy ? 0 : 1);
      en = 0;
      pre = 0;
      win = 0;
      cnt = 0;
      exp_rst = 1'b0;
      exp_rd = 8'h00;
      // running shows the always-on fuse from the first cycle after release
      exp_run = (lvl == 2);
      checking = 1'b1;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // compare in mid-cycle, once the edge's updates have landed
   always @(negedge clock_in) begin
      if (checking) begin
         tests_run += 2;
         if (rd_data_out !== exp_rd)
            report("read data");
         if (chip_reset_out !== exp_rst)
            report("time-out pulse");
         // running is a registered level, so it is checked every cycle
         tests_run++;
         if (wdog_running_out !== exp_run)
            report("running flag");
      end
   end

   // hang guard, well above the expected 1600 or so cycles
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         report("timeout");
         tally_and_finish();
      end
   end

   //////////////////////////////////////////////////////////////////////////
   initial begin
      clock_in = 1'b0;
      rst_in = 1'b1;
      {legacy_compat_fuse_in, wdog_always_on_fuse_in} = 2'b00;
      {wr_en_in, rd_en_in, wdog_kick_in, osc_tick_in} = 4'h0;
      addr_in = 8'h00;
      wr_data_in = 8'h00;
      void'($urandom(98));
      // all four fuse pairs: levels 1, 2, 0, 2
      for (int f = 0; f < 4; f++) begin
         do_reset(f[1], f[0]);
         foreach (SEQ[i])
            step(SEQ[i][8], SEQ[i][9], 0, 0, CTRL_ADDR, 8'(SEQ[i]));
         // unlock, period 32 ticks, a kick just short of expiry, then expiry
         step(1, 0, 0, 0, CTRL_ADDR, 8'h18);
         step(1, 0, 0, 0, CTRL_ADDR, 8'h09);
         repeat (31) step(0, 0, 0, 1, CTRL_ADDR, 8'h00);
         step(0, 0, 1, 1, CTRL_ADDR, 8'h00);
         repeat (34) step(0, 0, 0, 1, CTRL_ADDR, 8'h00);
         // random traffic, some of it to unmapped addresses
         repeat (300) begin
            w = ($urandom % 3) == 0;
            r = !w && ($urandom % 2) != 0;
            k = ($urandom % 16) == 0;
            t = !w && ($urandom % 2) != 0;
            step(w, r, k, t, ($urandom % 4) == 0 ?
                 8'($urandom_range(255, 1)) : CTRL_ADDR,
                 8'($urandom));
         end
      end
      tally_and_finish();
   end
endmodule
